// file: cid_decode.sv
// Summary of operation
// - machine cycle is two system clocks
// - lengths 1-3 bytes; times 1,2,4 cycles
// - register number from opcode bits 2:0
// - absolute jump/call carry page bits
// - add and add-with-carry opcode map
// - subtract, inc, dec, adjust, pointer increment
// - AND forms, immediate-to-direct three bytes
// - OR forms, immediate-to-direct three bytes
// - XOR forms, immediate-to-direct three bytes
// - single-byte accumulator operations and no-op
// - register move forms and their times
// - direct-destination moves take two cycles, except move from accumulator (F5) in one
// - code reads and pointer load
// - external data moves, 8/16-bit address
// - stack push C0, pop D0
// - exchange forms, one cycle
// - bit clear, set, complement, moves
// - carry logic with direct bit
// - long call/jump, returns
// - relative and indirect branches
// - compare-branch and decrement-branch forms
// - A5 chosen by extended select field
`timescale 1ns/1ps
`include "cid_map.svh"

module cid_decode (
  // clock and reset
  input  wire logic                 I_CORE_CLK,
  input  wire logic                 I_RST_N,
  // program memory fetch
  input  wire logic                 I_FETCH_VALID,
  input  wire logic [7:0]           I_FETCH_BYTE,
  output wire logic                 O_FETCH_READY,
  // extended_operation_select field
  input  wire logic [3:0]           I_EXT_OP_SEL,
  // datapath side
  output wire logic                 O_ISSUE,
  output wire cid_pkg::cid_insn_s   O_INSN,
  output wire cid_pkg::cid_strobe_s O_STROBE,
  output wire logic                 O_MC_TICK,
  output wire logic                 O_DONE,
  output wire logic                 O_BUSY
);
  typedef enum logic [1:0] {S_OPC, S_OPND, S_EXEC} cid_state_e;

  cid_state_e           state_q;
  cid_state_e           state_d;
  cid_pkg::cid_insn_s   insn_q;
  cid_pkg::cid_insn_s   new_insn;
  cid_pkg::cid_strobe_s strobe_q;
  cid_pkg::cid_dec_s    dec_c;
  cid_pkg::cid_dec_s    ext_dec;
  cid_pkg::cid_am_e     om;
  cid_pkg::cid_op_e     alu_op;
  cid_pkg::cid_op_e     issue_op;
  logic [1:0]           need_q;
  logic [2:0]           mc_q;
  logic                 issue_q;
  logic                 mc_tick;

  function automatic cid_pkg::cid_dec_s mk(input cid_pkg::cid_op_e op,
                                           input cid_pkg::cid_am_e src,
                                           input cid_pkg::cid_am_e dst,
                                           input logic [1:0]       len,
                                           input logic [2:0]       mc);
    return '{op, src, dst, len, mc};
  endfunction

  function automatic cid_pkg::cid_dec_s mkn(input cid_pkg::cid_op_e op,
                                            input logic [1:0]       len,
                                            input logic [2:0]       mc);
    return '{op, cid_pkg::AM_NONE, cid_pkg::AM_NONE, len, mc};
  endfunction

  function automatic cid_pkg::cid_strobe_s strobe_of(input cid_pkg::cid_op_e op,
                                                     input logic [7:0]       opc);
    cid_pkg::cid_strobe_s s;
    s = '0;
    s.code_rd  = (op == cid_pkg::OP_MOVC_DPTR) || (op == cid_pkg::OP_MOVC_PC);
    s.xdata_rd = (op == cid_pkg::OP_MOVX_RD);
    s.xdata_wr = (op == cid_pkg::OP_MOVX_WR);
    s.xaddr16  = (s.xdata_rd || s.xdata_wr) && !opc[1];
    s.pmem_wr  = (op == cid_pkg::OP_PSTORE);
    s.brk      = (op == cid_pkg::OP_TRAP);
    return s;
  endfunction

  // opcode field decode
  wire [7:0] opc    = I_FETCH_BYTE;
  wire [3:0] hi     = opc[7:4];
  wire [3:0] lo     = opc[3:0];
  wire       is_imm = (lo == 4'h4);
  wire       is_dir = (lo == 4'h5);
  wire       is_ind = (opc[3:1] == 3'b011);
  wire [1:0] glen   = (is_dir || is_imm) ? 2'd2 : 2'd1;

  assign om = opc[3] ? cid_pkg::AM_REG : is_ind ? cid_pkg::AM_IND :
              is_dir ? cid_pkg::AM_DIR : cid_pkg::AM_IMM;

  assign alu_op = (hi == 4'h2) ? cid_pkg::OP_ADD :
                  (hi == 4'h3) ? cid_pkg::OP_ADDC :
                  (hi == 4'h4) ? cid_pkg::OP_ORL :
                  (hi == 4'h5) ? cid_pkg::OP_ANL :
                  (hi == 4'h6) ? cid_pkg::OP_XRL : cid_pkg::OP_SUBB;

  // the select field is read in the cycle the opcode is taken
  assign ext_dec = (I_EXT_OP_SEL == `CID_EXT_PSTORE) ?
                   mk(cid_pkg::OP_PSTORE, cid_pkg::AM_ACC, cid_pkg::AM_CODE, 2'd1, 3'd2) :
                   (I_EXT_OP_SEL == `CID_EXT_TRAP) ? mkn(cid_pkg::OP_TRAP, 2'd1, 3'd1) :
                   mkn(cid_pkg::OP_UNDEF, 2'd1, 3'd1);

  always_comb begin
    dec_c = mkn(cid_pkg::OP_UNDEF, 2'd1, 3'd1);
    if (lo >= 4'h4) begin
      unique case (hi)
        4'h0, 4'h1: begin
          dec_c = mk(hi[0] ? cid_pkg::OP_DEC : cid_pkg::OP_INC, cid_pkg::AM_NONE,
                     is_imm ? cid_pkg::AM_ACC : om, is_imm ? 2'd1 : glen, 3'd1);
        end
        4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9: begin
          dec_c = mk(alu_op, om, cid_pkg::AM_ACC, glen, 3'd1);
        end
        4'h7: begin
          dec_c = mk(cid_pkg::OP_MOV, cid_pkg::AM_IMM, is_imm ? cid_pkg::AM_ACC : om,
                     is_dir ? 2'd3 : 2'd2, is_dir ? 3'd2 : 3'd1);
        end
        4'h8: begin
          dec_c = is_imm ? mkn(cid_pkg::OP_DIV, 2'd1, 3'd4) :
                  mk(cid_pkg::OP_MOV, om, cid_pkg::AM_DIR,
                     is_dir ? 2'd3 : 2'd2, 3'd2);
        end
        4'hA: begin
          dec_c = is_imm ? mkn(cid_pkg::OP_MUL, 2'd1, 3'd4) : is_dir ? ext_dec :
                  mk(cid_pkg::OP_MOV, cid_pkg::AM_DIR, om, 2'd2, 3'd2);
        end
        4'hB: begin
          dec_c = mk(cid_pkg::OP_CJNE, is_dir ? cid_pkg::AM_DIR : cid_pkg::AM_IMM,
                     (is_imm || is_dir) ? cid_pkg::AM_ACC : om, 2'd3, 3'd2);
        end
        4'hC: begin
          dec_c = is_imm ? mk(cid_pkg::OP_SWAP, cid_pkg::AM_ACC, cid_pkg::AM_ACC, 2'd1, 3'd1) :
                  mk(cid_pkg::OP_XCH, om, cid_pkg::AM_ACC, glen, 3'd1);
        end
        4'hD: begin
          dec_c = is_imm ? mk(cid_pkg::OP_DA, cid_pkg::AM_ACC, cid_pkg::AM_ACC, 2'd1, 3'd1) :
                  is_dir ? mk(cid_pkg::OP_DJNZ, om, om, 2'd3, 3'd2) :
                  is_ind ? mk(cid_pkg::OP_XCHD, om, cid_pkg::AM_ACC, 2'd1, 3'd1) :
                  mk(cid_pkg::OP_DJNZ, om, om, 2'd2, 3'd2);
        end
        4'hE: begin
          dec_c = is_imm ? mk(cid_pkg::OP_CLR_A, cid_pkg::AM_NONE, cid_pkg::AM_ACC, 2'd1, 3'd1) :
                  mk(cid_pkg::OP_MOV, om, cid_pkg::AM_ACC, glen, 3'd1);
        end
        4'hF: begin
          dec_c = is_imm ? mk(cid_pkg::OP_CPL_A, cid_pkg::AM_ACC, cid_pkg::AM_ACC, 2'd1, 3'd1) :
                  mk(cid_pkg::OP_MOV, cid_pkg::AM_ACC, om, glen, 3'd1);
        end
      endcase
    end else if (lo == 4'h1) begin
      dec_c = mkn(opc[4] ? cid_pkg::OP_ACALL : cid_pkg::OP_AJMP, 2'd2, 3'd2);
    end else begin
      unique case (opc)
        8'h00: dec_c = mkn(cid_pkg::OP_NOP, 2'd1, 3'd1);
        8'h02: dec_c = mkn(cid_pkg::OP_LJMP, 2'd3, 3'd2);
        8'h03: dec_c = mk(cid_pkg::OP_RR, cid_pkg::AM_ACC, cid_pkg::AM_ACC, 2'd1, 3'd1);
        8'h10: dec_c = mk(cid_pkg::OP_JBC, cid_pkg::AM_BIT, cid_pkg::AM_BIT, 2'd3, 3'd2);
        8'h12: dec_c = mkn(cid_pkg::OP_LCALL, 2'd3, 3'd2);
        8'h13: dec_c = mk(cid_pkg::OP_RRC, cid_pkg::AM_ACC, cid_pkg::AM_ACC, 2'd1, 3'd1);
        8'h20: dec_c = mk(cid_pkg::OP_JB, cid_pkg::AM_BIT, cid_pkg::AM_NONE, 2'd3, 3'd2);
        8'h22: dec_c = mkn(cid_pkg::OP_RET, 2'd1, 3'd2);
        8'h23: dec_c = mk(cid_pkg::OP_RL, cid_pkg::AM_ACC, cid_pkg::AM_ACC, 2'd1, 3'd1);
        8'h30: dec_c = mk(cid_pkg::OP_JNB, cid_pkg::AM_BIT, cid_pkg::AM_NONE, 2'd3, 3'd2);
        8'h32: dec_c = mkn(cid_pkg::OP_RETI, 2'd1, 3'd2);
        8'h33: dec_c = mk(cid_pkg::OP_RLC, cid_pkg::AM_ACC, cid_pkg::AM_ACC, 2'd1, 3'd1);
        8'h40: dec_c = mk(cid_pkg::OP_JC, cid_pkg::AM_CARRY, cid_pkg::AM_NONE, 2'd2, 3'd2);
        8'h42: dec_c = mk(cid_pkg::OP_ORL, cid_pkg::AM_ACC, cid_pkg::AM_DIR, 2'd2, 3'd1);
        8'h43: dec_c = mk(cid_pkg::OP_ORL, cid_pkg::AM_IMM, cid_pkg::AM_DIR, 2'd3, 3'd2);
        8'h50: dec_c = mk(cid_pkg::OP_JNC, cid_pkg::AM_CARRY, cid_pkg::AM_NONE, 2'd2, 3'd2);
        8'h52: dec_c = mk(cid_pkg::OP_ANL, cid_pkg::AM_ACC, cid_pkg::AM_DIR, 2'd2, 3'd1);
        8'h53: dec_c = mk(cid_pkg::OP_ANL, cid_pkg::AM_IMM, cid_pkg::AM_DIR, 2'd3, 3'd2);
        8'h60: dec_c = mk(cid_pkg::OP_JZ, cid_pkg::AM_ACC, cid_pkg::AM_NONE, 2'd2, 3'd2);
        8'h62: dec_c = mk(cid_pkg::OP_XRL, cid_pkg::AM_ACC, cid_pkg::AM_DIR, 2'd2, 3'd1);
        8'h63: dec_c = mk(cid_pkg::OP_XRL, cid_pkg::AM_IMM, cid_pkg::AM_DIR, 2'd3, 3'd2);
        8'h70: dec_c = mk(cid_pkg::OP_JNZ, cid_pkg::AM_ACC, cid_pkg::AM_NONE, 2'd2, 3'd2);
        8'h72: dec_c = mk(cid_pkg::OP_ORL_C, cid_pkg::AM_BIT, cid_pkg::AM_CARRY, 2'd2, 3'd2);
        8'h73: dec_c = mk(cid_pkg::OP_JMP_IND, cid_pkg::AM_DPTR, cid_pkg::AM_NONE, 2'd1, 3'd2);
        8'h80: dec_c = mkn(cid_pkg::OP_SJMP, 2'd2, 3'd2);
        8'h82: dec_c = mk(cid_pkg::OP_ANL_C, cid_pkg::AM_BIT, cid_pkg::AM_CARRY,
                          2'd2, 3'd2);
        8'h83: dec_c = mk(cid_pkg::OP_MOVC_PC, cid_pkg::AM_CODE, cid_pkg::AM_ACC, 2'd1, 3'd2);
        8'h90: dec_c = mk(cid_pkg::OP_MOV_DPTR, cid_pkg::AM_IMM, cid_pkg::AM_DPTR, 2'd3, 3'd2);
        8'h92: dec_c = mk(cid_pkg::OP_MOV_BIT_C, cid_pkg::AM_CARRY, cid_pkg::AM_BIT,
                          2'd2, 3'd2);
        8'h93: dec_c = mk(cid_pkg::OP_MOVC_DPTR, cid_pkg::AM_CODE, cid_pkg::AM_ACC, 2'd1, 3'd2);
        8'hA0: dec_c = mk(cid_pkg::OP_ORL_CN, cid_pkg::AM_BIT, cid_pkg::AM_CARRY, 2'd2, 3'd2);
        8'hA2: dec_c = mk(cid_pkg::OP_MOV_C_BIT, cid_pkg::AM_BIT, cid_pkg::AM_CARRY, 2'd2, 3'd1);
        8'hA3: dec_c = mk(cid_pkg::OP_INC_DPTR, cid_pkg::AM_DPTR, cid_pkg::AM_DPTR, 2'd1, 3'd2);
        8'hB0: dec_c = mk(cid_pkg::OP_ANL_CN, cid_pkg::AM_BIT, cid_pkg::AM_CARRY, 2'd2, 3'd2);
        8'hB2: dec_c = mk(cid_pkg::OP_CPL_BIT, cid_pkg::AM_BIT, cid_pkg::AM_BIT, 2'd2, 3'd1);
        8'hB3: dec_c = mk(cid_pkg::OP_CPL_BIT, cid_pkg::AM_CARRY, cid_pkg::AM_CARRY, 2'd1, 3'd1);
        8'hC0: dec_c = mk(cid_pkg::OP_PUSH, cid_pkg::AM_DIR, cid_pkg::AM_NONE,
                          2'd2, 3'd2);
        8'hC2: dec_c = mk(cid_pkg::OP_CLR_BIT, cid_pkg::AM_NONE, cid_pkg::AM_BIT, 2'd2, 3'd1);
        8'hC3: dec_c = mk(cid_pkg::OP_CLR_BIT, cid_pkg::AM_NONE, cid_pkg::AM_CARRY, 2'd1, 3'd1);
        8'hD0: dec_c = mk(cid_pkg::OP_POP, cid_pkg::AM_NONE, cid_pkg::AM_DIR, 2'd2, 3'd2);
        8'hD2: dec_c = mk(cid_pkg::OP_SET_BIT, cid_pkg::AM_NONE, cid_pkg::AM_BIT, 2'd2, 3'd1);
        8'hD3: dec_c = mk(cid_pkg::OP_SET_BIT, cid_pkg::AM_NONE, cid_pkg::AM_CARRY, 2'd1, 3'd1);
        8'hE0, 8'hE2, 8'hE3: begin
          dec_c = mk(cid_pkg::OP_MOVX_RD, cid_pkg::AM_XDATA, cid_pkg::AM_ACC, 2'd1, 3'd2);
        end
        8'hF0, 8'hF2, 8'hF3: begin
          dec_c = mk(cid_pkg::OP_MOVX_WR, cid_pkg::AM_ACC, cid_pkg::AM_XDATA, 2'd1, 3'd2);
        end
        // lo 4..F and lo 1 are decoded above and never land here
        default: dec_c = mkn(cid_pkg::OP_UNDEF, 2'd1, 3'd1);
      endcase
    end
  end

  // fetch sequencing
  wire acc_opc    = (state_q == S_OPC) && I_FETCH_VALID;
  wire acc_opnd   = (state_q == S_OPND) && I_FETCH_VALID;
  wire last_opnd  = acc_opnd && (need_q == 2'd1);
  wire issue_now  = (acc_opc && (dec_c.len == 2'd1)) || last_opnd;
  wire first_opnd = (need_q == (insn_q.dec.len - 2'd1));
  wire [7:0] issue_opc = (state_q == S_OPC) ? opc : insn_q.opcode;
  wire done = (state_q == S_EXEC) && mc_tick && (mc_q == (insn_q.dec.mcyc - 3'd1));

  assign issue_op = (state_q == S_OPC) ? dec_c.op : insn_q.dec.op;
  assign new_insn = '{dec_c, opc, 8'h00, 8'h00, opc[2:0], opc[7:5],
                      dec_c.op == cid_pkg::OP_UNDEF};

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_OPC:  if (acc_opc) state_d = (dec_c.len == 2'd1) ? S_EXEC : S_OPND;
      S_OPND: if (last_opnd) state_d = S_EXEC;
      S_EXEC: if (done) state_d = S_OPC;
    endcase
  end

  cid_mcycle u_mcycle (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_run   (state_q == S_EXEC),
    .o_tick  (mc_tick)
  );

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q <= S_OPC;
      issue_q <= 1'b0;
    end else begin
      state_q <= state_d;
      issue_q <= issue_now;
    end
  end

  // operand bytes arrive in program order after the opcode
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      insn_q <= '0;
      need_q <= 2'd0;
    end else if (acc_opc) begin
      insn_q <= new_insn;
      need_q <= dec_c.len - 2'd1;
    end else if (acc_opnd) begin
      need_q <= need_q - 2'd1;
      if (first_opnd) begin
        insn_q.opnd1 <= I_FETCH_BYTE;
      end else begin
        insn_q.opnd2 <= I_FETCH_BYTE;
      end
    end
  end

  // undefined codes map to an all-zero strobe set
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      strobe_q <= '0;
    end else begin
      strobe_q <= issue_now ? strobe_of(issue_op, issue_opc) : '0;
    end
  end

  // machine cycles spent in the current instruction
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mc_q <= 3'd0;
    end else if (state_q != S_EXEC) begin
      mc_q <= 3'd0;
    end else if (mc_tick) begin
      mc_q <= mc_q + 3'd1;
    end
  end

  assign O_FETCH_READY = (state_q == S_OPC) || (state_q == S_OPND);
  assign O_ISSUE       = issue_q;
  assign O_INSN        = insn_q;
  assign O_STROBE      = strobe_q;
  assign O_MC_TICK     = mc_tick;
  assign O_DONE        = done;
  assign O_BUSY        = (state_q != S_OPC);

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_N);

  a_mc_two_clk:
    assert property (O_ISSUE |-> !O_MC_TICK ##1 O_MC_TICK ##1 !O_MC_TICK)
    else $error("machine cycle not two clocks");
  a_four_cycle:
    assert property (O_ISSUE && O_INSN.dec.mcyc == 3'd4 |-> !O_DONE [*7] ##1 O_DONE)
    else $error("four-cycle instruction wrong length");
  a_two_cycle:
    assert property (O_ISSUE && O_INSN.dec.mcyc == 3'd2 |-> !O_DONE [*3] ##1 O_DONE)
    else $error("two-cycle instruction wrong length");
  a_muldiv_time:
    assert property (O_ISSUE && (O_INSN.opcode == `CID_OPC_MUL ||
                     O_INSN.opcode == `CID_OPC_DIV) |-> O_INSN.dec.mcyc == 3'd4)
    else $error("multiply or divide not four cycles");
  a_reg_number:
    assert property (O_ISSUE && (O_INSN.dec.src == cid_pkg::AM_REG ||
                     O_INSN.dec.dst == cid_pkg::AM_REG)
                     |-> O_INSN.rn == O_INSN.opcode[2:0] && O_INSN.opcode[3])
    else $error("register number mismatch");
  a_abs_page:
    assert property (O_ISSUE && O_INSN.opcode[3:0] == 4'h1 |-> O_INSN.dec.len == 2'd2
                     && O_INSN.page == O_INSN.opcode[7:5] && (O_INSN.dec.op ==
                     (O_INSN.opcode[4] ? cid_pkg::OP_ACALL : cid_pkg::OP_AJMP)))
    else $error("absolute jump or call wrong");
  a_add_forms:
    assert property (O_ISSUE && O_INSN.opcode[7:5] == 3'b001 && O_INSN.opcode[3:2] != 2'b00
                     |-> O_INSN.dec.op inside {cid_pkg::OP_ADD, cid_pkg::OP_ADDC}
                     && O_INSN.dec.mcyc == 3'd1)
    else $error("add decode wrong");
  a_dptr_inc:
    assert property (O_ISSUE && O_INSN.opcode == 8'hA3
                     |-> O_INSN.dec.op == cid_pkg::OP_INC_DPTR && O_INSN.dec.mcyc == 3'd2)
    else $error("pointer increment wrong");
  a_logic_imm:
    assert property (O_ISSUE && O_INSN.opcode inside {8'h43, 8'h53, 8'h63}
                     |-> O_INSN.dec.len == 2'd3 && O_INSN.dec.mcyc == 3'd2)
    else $error("logic immediate-to-direct wrong");
  a_swap_acc:
    assert property (O_ISSUE && O_INSN.opcode == 8'hC4
                     |-> O_INSN.dec.op == cid_pkg::OP_SWAP && O_INSN.dec.len == 2'd1)
    else $error("nibble swap wrong");
  a_mov_dir_reg:
    assert property (O_ISSUE && O_INSN.opcode[7:3] == 5'b10101
                     |-> O_INSN.dec.dst == cid_pkg::AM_REG && O_INSN.dec.mcyc == 3'd2)
    else $error("direct to register move wrong");
  a_mov_dir_dir:
    assert property (O_ISSUE && O_INSN.opcode inside {8'h85, 8'h75}
                     |-> O_INSN.dec.len == 2'd3 && O_INSN.dec.mcyc == 3'd2)
    else $error("direct-destination move wrong");
  a_code_read:
    assert property (O_ISSUE && O_INSN.opcode inside {8'h83, 8'h93}
                     |-> O_STROBE.code_rd && O_INSN.dec.mcyc == 3'd2)
    else $error("code read strobe missing");
  a_xdata_16:
    assert property (O_ISSUE && O_INSN.opcode inside {8'hE0, 8'hF0}
                     |-> O_STROBE.xaddr16 && (O_STROBE.xdata_rd != O_STROBE.xdata_wr))
    else $error("external data strobe wrong");
  a_stack_ops:
    assert property (O_ISSUE && O_INSN.opcode inside {8'hC0, 8'hD0}
                     |-> O_INSN.dec.len == 2'd2 && O_INSN.dec.mcyc == 3'd2)
    else $error("push or pop wrong");
  a_xchd_ind:
    assert property (O_ISSUE && O_INSN.opcode[7:1] == 7'b1101011
                     |-> O_INSN.dec.op == cid_pkg::OP_XCHD && O_INSN.dec.mcyc == 3'd1)
    else $error("nibble exchange wrong");
  a_bit_move:
    assert property (O_ISSUE && O_INSN.opcode == 8'h92 |-> O_INSN.dec.mcyc == 3'd2)
    else $error("carry-to-bit move wrong");
  a_carry_logic:
    assert property (O_ISSUE && O_INSN.opcode inside {8'h82, 8'hB0, 8'h72, 8'hA0}
                     |-> O_INSN.dec.dst == cid_pkg::AM_CARRY && O_INSN.dec.mcyc == 3'd2)
    else $error("carry logic wrong");
  a_long_xfer:
    assert property (O_ISSUE && O_INSN.opcode inside {8'h02, 8'h12} |-> O_INSN.dec.len == 2'd3)
    else $error("long jump or call wrong");
  a_jmp_ind:
    assert property (O_ISSUE && O_INSN.opcode == 8'h73
                     |-> O_INSN.dec.op == cid_pkg::OP_JMP_IND && O_INSN.dec.mcyc == 3'd2)
    else $error("indirect jump wrong");
  a_cjne_len:
    assert property (O_ISSUE && O_INSN.dec.op == cid_pkg::OP_CJNE
                     |-> O_INSN.dec.len == 2'd3 && O_INSN.dec.mcyc == 3'd2)
    else $error("compare-branch wrong");
  a_ext_store:
    assert property (O_ISSUE && O_INSN.dec.op == cid_pkg::OP_PSTORE
                     |-> O_STROBE.pmem_wr ##1 !O_DONE [*2] ##1 O_DONE)
    else $error("program store wrong");
  a_undef_quiet:
    assert property (O_ISSUE && O_INSN.undef |-> O_STROBE == '0 ##1 O_DONE)
    else $error("undefined opcode had effects");
endmodule

// file: cid_fetch_src.sv
`timescale 1ns/1ps

module cid_fetch_src (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // fetch handshake
  input  wire logic       i_ready,
  output logic            o_valid,
  output logic [7:0]      o_byte
);
  logic [7:0] q_q[$];
  task automatic push(input logic [7:0] b);
    q_q.push_back(b);
  endtask
  initial begin
    o_valid = 1'b0;
    o_byte  = 8'h00;
  end
  // byte held until taken; idle bus toggles each clock between the last byte and its inverse
  always @(posedge i_clk) begin
    if (i_rst_n && o_valid && i_ready) void'(q_q.pop_front());
    if (q_q.size() != 0) begin
      o_valid <= 1'b1;
      o_byte  <= q_q[0];
    end else begin
      o_valid <= 1'b0;
      o_byte  <= ~o_byte;
    end
  end
endmodule

// file: cid_map.svh
`ifndef CID_MAP_SVH
`define CID_MAP_SVH

// system clocks per machine cycle
`define CID_MC_CLKS 2

// extended-operation select values, the whole 4-bit select field
`define CID_EXT_PSTORE 4'h1
`define CID_EXT_TRAP 4'h2

// opcodes that need special handling
`define CID_OPC_EXT 8'hA5
`define CID_OPC_MUL 8'hA4
`define CID_OPC_DIV 8'h84

`endif

// file: cid_mcycle.sv
`timescale 1ns/1ps
`include "cid_map.svh"

module cid_mcycle (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // control
  input  wire logic i_run,
  output wire logic o_tick
);
  localparam int unsigned W = $clog2(`CID_MC_CLKS);
  localparam logic [W-1:0] LAST = W'(`CID_MC_CLKS - 1);

  logic [W-1:0] cnt_q;

  // phase restarts with every instruction so ticks align to its start
  assign o_tick = i_run && (cnt_q == LAST);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (!i_run || o_tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

// file: cid_pkg.sv
package cid_pkg;

  typedef enum logic [5:0] {
    OP_UNDEF, OP_NOP, OP_ADD, OP_ADDC, OP_SUBB, OP_INC, OP_DEC, OP_INC_DPTR, OP_MUL,
    OP_DIV, OP_DA, OP_ANL, OP_ORL, OP_XRL, OP_CLR_A, OP_CPL_A, OP_SWAP, OP_RL, OP_RLC,
    OP_RR, OP_RRC, OP_MOV, OP_MOV_DPTR, OP_MOVC_DPTR, OP_MOVC_PC, OP_MOVX_RD, OP_MOVX_WR,
    OP_PUSH, OP_POP, OP_XCH, OP_XCHD, OP_CLR_BIT, OP_SET_BIT, OP_CPL_BIT, OP_ANL_C,
    OP_ANL_CN, OP_ORL_C, OP_ORL_CN, OP_MOV_C_BIT, OP_MOV_BIT_C, OP_AJMP, OP_ACALL,
    OP_LJMP, OP_LCALL, OP_RET, OP_RETI, OP_SJMP, OP_JC, OP_JNC, OP_JB, OP_JNB, OP_JBC,
    OP_JMP_IND, OP_JZ, OP_JNZ, OP_CJNE, OP_DJNZ, OP_PSTORE, OP_TRAP
  } cid_op_e;

  typedef enum logic [3:0] {
    AM_NONE, AM_ACC, AM_REG, AM_DIR, AM_IND, AM_IMM, AM_CARRY, AM_BIT, AM_DPTR,
    AM_CODE, AM_XDATA
  } cid_am_e;

  typedef struct packed {
    cid_op_e    op;
    cid_am_e    src;
    cid_am_e    dst;
    logic [1:0] len;
    logic [2:0] mcyc;
  } cid_dec_s;

  typedef struct packed {
    cid_dec_s   dec;
    logic [7:0] opcode;
    logic [7:0] opnd1;
    logic [7:0] opnd2;
    logic [2:0] rn;
    logic [2:0] page;
    logic       undef;
  } cid_insn_s;

  typedef struct packed {
    logic code_rd;
    logic xdata_rd;
    logic xdata_wr;
    logic xaddr16;
    logic pmem_wr;
    logic brk;
  } cid_strobe_s;

endpackage

// file: cpu_instruction_decode_test.sv
`timescale 1ns/1ps
`define CMP(nm, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s); end end

module cpu_instruction_decode_test;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 valid, ready, issue, tick, done, busy;
  logic [7:0]           fbyte;
  logic [3:0]           ext_sel = 4'h0;
  cid_pkg::cid_insn_s   insn;
  cid_pkg::cid_strobe_s strobe;
  int                   fails = 0;
  int                   n_compared = 0;
  // per-opcode byte counts and machine cycles, 16 per upper nibble, four nibbles per line
  string lens = {"1231121111111111323112111111111132112211111111113211221111111111",
                 "2223221111111111222322111111111122232211111111112221232222222222",
                 "2221132222222222322122111111111122211122222222222221333333333333",
                 "2221121111111111222113112222222212111211111111111211121111111111"};
  string cycs = {"1221111111111111222111111111111122211111111111112221111111111111",
                 "2212111111111111221211111111111122121111111111112222121111111111",
                 "2222422222222222222211111111111122124122222222222211222222222222",
                 "2211111111111111221112112222222222221111111111112222111111111111"};
  always #4 clk = ~clk;
  cid_fetch_src src_u (.i_clk(clk), .i_rst_n(rst_n), .i_ready(ready), .o_valid(valid),
                       .o_byte(fbyte));
  cid_decode dut_u (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_FETCH_VALID(valid),
                    .I_FETCH_BYTE(fbyte), .O_FETCH_READY(ready), .I_EXT_OP_SEL(ext_sel),
                    .O_ISSUE(issue), .O_INSN(insn), .O_STROBE(strobe), .O_MC_TICK(tick),
                    .O_DONE(done), .O_BUSY(busy));
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic run(input logic [7:0] op, input logic [3:0] sel);
    int         ln, mc, n, k;
    logic [7:0] b1, b2;
    logic [5:0] xs;
    cid_pkg::cid_op_e eo;
    ln = lens[op] - 8'h30;
    mc = (op == 8'hA5 && sel == 4'h1) ? 2 : cycs[op] - 8'h30;
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    xs = {op == 8'h83 || op == 8'h93, op inside {8'hE0, 8'hE2, 8'hE3},
          op inside {8'hF0, 8'hF2, 8'hF3}, op == 8'hE0 || op == 8'hF0,
          op == 8'hA5 && sel == 4'h1, op == 8'hA5 && sel == 4'h2};
    // random idle gap so the source is sometimes late
    repeat (2'($urandom)) @(posedge clk);
    @(posedge clk);
    ext_sel <= sel;
    src_u.push(op);
    if (ln > 1) src_u.push(b1);
    if (ln > 2) src_u.push(b2);
    for (n = 0; n < 30 && issue !== 1'b1; n++) @(negedge clk);
    if (n == 30) begin
      fails++;
      close_out;
    end
    `CMP("len", 2'(ln), insn.dec.len)
    `CMP("mcyc", 3'(mc), insn.dec.mcyc)
    `CMP("opcode", op, insn.opcode)
    `CMP("opnd1", ln > 1 ? b1 : 8'h00, insn.opnd1)
    `CMP("opnd2", ln > 2 ? b2 : 8'h00, insn.opnd2)
    `CMP("rn", op[2:0], insn.rn)
    `CMP("page", op[7:5], insn.page)
    `CMP("undef", op == 8'hA5 && !(sel inside {4'h1, 4'h2}), insn.undef)
    `CMP("strobe", xs, strobe)
    `CMP("busy", 1'b1, busy)
    `CMP("ready", 1'b0, ready)
    eo = cid_pkg::OP_UNDEF;
    case (op)
      8'h00: eo = cid_pkg::OP_NOP;
      8'h84: eo = cid_pkg::OP_DIV;
      8'hA4: eo = cid_pkg::OP_MUL;
      8'hA3: eo = cid_pkg::OP_INC_DPTR;
      8'hC0: eo = cid_pkg::OP_PUSH;
      8'hD0: eo = cid_pkg::OP_POP;
      8'hA5: eo = (sel == 4'h1) ? cid_pkg::OP_PSTORE :
                  (sel == 4'h2) ? cid_pkg::OP_TRAP : cid_pkg::OP_UNDEF;
      default: ;
    endcase
    if (eo != cid_pkg::OP_UNDEF || op == 8'hA5) `CMP("op", eo, insn.dec.op)
    k = 0;
    for (n = 1; n < 30; n++) begin
      if (tick === 1'b1) k++;
      if (done === 1'b1) break;
      @(negedge clk);
    end
    if (n == 30) begin
      fails++;
      close_out;
    end
    `CMP("clocks", 2 * mc, n)
    `CMP("ticks", mc, k)
    @(negedge clk);
    `CMP("ready after", 1'b1, ready)
    `CMP("busy after", 1'b0, busy)
  endtask
  initial begin
    void'($urandom(32'hE544));
    repeat (6) @(posedge clk);
    `CMP("ready in reset", 1'b1, ready)
    `CMP("busy in reset", 1'b0, busy)
    rst_n <= 1'b1;
    for (int i = 0; i < 256; i++) run(8'(i), 4'($urandom));
    for (int s = 0; s < 16; s++) run(8'hA5, 4'(s));
    repeat (300) run(8'($urandom), 4'($urandom));
    close_out;
  end
endmodule
